// *** rcp_defs.vh ***
// Constants for the radio control port: addresses, reset values, bit positions, codes
`ifndef RCP_DEFS_VH
`define RCP_DEFS_VH

// ****************************************************************
// Special-function addresses
// ****************************************************************
`define RCP_ADDR_PIN      8'ha0
`define RCP_ADDR_SHDATA   8'hb2
`define RCP_ADDR_ROUTE    8'hb3

// ****************************************************************
// Reset values
// ****************************************************************
`define RCP_PIN_RESET     8'h80
`define RCP_ROUTE_RESET   2'h0

// ****************************************************************
// Read bit map of the radio pin register
// ****************************************************************
`define RCP_RD_CH2_READY  6
`define RCP_RD_CH2_CLOCK  5
`define RCP_RD_CH2_SOUT   4
`define RCP_RD_CH1_READY  2
`define RCP_RD_CH1_CLOCK  1
`define RCP_RD_CH1_DATA   0

// ****************************************************************
// Write bit map of the radio pin register
// ****************************************************************
`define RCP_WR_POWER_ON   7
`define RCP_WR_ACTIVATE   6
`define RCP_WR_CH2_CLOCK  5
`define RCP_WR_CFG_SELECT 3
`define RCP_WR_CH1_CLOCK  1
`define RCP_WR_DATA_IN    0

// ****************************************************************
// Serial routing codes
// ****************************************************************
`define RCP_ROUTE_OFF     2'h0
`define RCP_ROUTE_PORT1   2'h1
`define RCP_ROUTE_CH1     2'h2
`define RCP_ROUTE_CH2     2'h3

// ****************************************************************
// Shifter timing
// ****************************************************************
`define RCP_SHIFT_BITS    4'h8
`define RCP_SCK_DIV       8

`endif

// *** rcp_fifo.v ***
// Receive byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rcp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             sys_clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;
    wire            push;
    wire            pop;

    // Honest full and empty from the fill count
    assign in_ready  = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data  = mem_q[rd_ptr_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage has no reset; only the pointers and the fill count carry reset state
    always @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                              : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                              : rd_ptr_q + 1'b1;
            end
            if (push & ~pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop & ~push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

// *** rcp_shifter.v ***
// Byte-wide serial shifter: eight clock pulses, msb first
`timescale 1ns/1ps
`include "rcp_defs.vh"
module rcp_shifter (
    input  wire       sys_clk,
    input  wire       rst_n,
    input  wire       tick,
    input  wire       start,
    input  wire [7:0] tx_byte,
    input  wire       sdi,
    output reg        sck_q,
    output reg        sdo_q,
    output wire [7:0] rx_byte,
    output reg        done_q,
    output reg        busy_q
);
    reg [7:0] shift_q;
    reg [3:0] bits_q;

    assign rx_byte = shift_q;

    // Ticks come at half the shift period, so the first rise is half a period
    // after the start; output moves on falls, and input is also taken on falls.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q   <= 1'b0;
            sdo_q   <= 1'b0;
            shift_q <= 8'h00;
            bits_q  <= 4'h0;
            done_q  <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                busy_q  <= 1'b1;
                sck_q   <= 1'b0;
                sdo_q   <= tx_byte[7];
                shift_q <= tx_byte;
                bits_q  <= 4'h0;
            end else if (busy_q && tick) begin
                if (!sck_q) begin
                    sck_q  <= 1'b1;
                    bits_q <= bits_q + 4'h1;
                end else begin
                    // Synced input lags the rise, so the bit is taken late in the high phase
                    sck_q   <= 1'b0;
                    shift_q <= {shift_q[6:0], sdi};
                    if (bits_q == `RCP_SHIFT_BITS) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end else begin
                        sdo_q <= shift_q[6];
                    end
                end
            end
        end
    end
endmodule

// *** rcp_radio_port.v ***
// Radio control port: pin register, serial routing, shifter and receive FIFO
`timescale 1ns/1ps
`include "rcp_defs.vh"
// Behaviour
// RL1 - Pin register at A0, read/write, resets to 80 hex.
// RL2 - Two-bit routing register at B3, reset zero, selects shifter destination.
// RL3 - Pin port not bidirectional: reads show radio outputs, writes drive inputs.
// RL4 - Read map: 6 ready2, 5 clock2, 4 sout2, 2 ready1, 1 clock1, 0 data.
// RL5 - Write map: 7 power, 6 activate, 5 clock2, 3 config select, 1 clock1, 0 data.
// RL6 - Both data-ready lines also offered to the CPU as interrupt sources.
// RL7 - Routing upper bit clear: radio pins follow register bits directly.
// RL8 - Routing 10: shifter clock on channel 1 clock, data both ways on data.
// RL9 - Routing 11: shifter clock on channel 2 clock, input from channel 2 out.
// RL10 - During reset: config select low, activate low, power-on high.
// RL11 - Control outputs keep defaults until software writes the pin register.
// RL12 - Software picks radio mode from power, activate, config select levels.
// RL13 - Software uses only buffered burst mode, never direct streaming.
// RL14 - Radio buffers slow CPU data and sends it over the air fast.
// RL15 - Three-wire programming rate set by how fast the clock line toggles.
// RL16 - Shifter data write sends 8 pulses msb first, capturing 8 input bits.
// RL17 - Configuration shifted msb first on clock 1 while select high, 18 bytes max.
// RL18 - Transmit: raise activate, clock address and payload, lower activate.
// RL19 - Radio raises ready1 on packet, lowers it after payload clocked out.
// RL20 - Pin register reads return current sampled radio outputs, not a latch.
module rcp_radio_port #(
    parameter SCK_DIV    = `RCP_SCK_DIV,
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW    = 3
) (
    input  wire       sys_clk,
    input  wire       rst_n,
    input  wire [7:0] sfr_addr,
    input  wire       sfr_wr,
    input  wire       sfr_rd,
    input  wire [7:0] sfr_wdata,
    output reg  [7:0] sfr_rdata,
    output wire       shift_wr_ready,
    output reg        shift_done,
    output wire       shift_busy,
    output wire       rx_byte_valid,
    output reg        radio_power_on,
    output reg        radio_activate,
    output reg        radio_cfg_select,
    output reg        ch1_clock,
    output reg        ch2_clock,
    output reg        radio_data_in,
    input  wire       ch1_data,
    input  wire       ch1_clock_echo,
    input  wire       ch1_data_ready,
    input  wire       ch2_serial_out,
    input  wire       ch2_clock_echo,
    input  wire       ch2_data_ready,
    output wire       ch1_ready_irq,
    output wire       ch2_ready_irq,
    output reg        p1_sck,
    output reg        p1_sdo,
    input  wire       p1_sdi
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam NSYNC = 7;
    wire [NSYNC-1:0] pin_raw;
    reg  [NSYNC-1:0] sync1_q;
    reg  [NSYNC-1:0] sync2_q;
    reg  [NSYNC-1:0] sync3_q;
    reg  [NSYNC-1:0] pin_q;

    assign pin_raw = {p1_sdi, ch2_data_ready, ch2_clock_echo, ch2_serial_out,
                      ch1_data_ready, ch1_clock_echo, ch1_data};

    // Three stages; a level is taken once stages two and three agree
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= {NSYNC{1'b0}};
            sync2_q <= {NSYNC{1'b0}};
            sync3_q <= {NSYNC{1'b0}};
            pin_q   <= {NSYNC{1'b0}};
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pin_q   <= (sync2_q & sync3_q) | (pin_q & (sync2_q | sync3_q));
        end
    end

    wire s_ch1_data  = pin_q[0];
    wire s_ch1_clock = pin_q[1];
    wire s_ch1_ready = pin_q[2];
    wire s_ch2_sout  = pin_q[3];
    wire s_ch2_clock = pin_q[4];
    wire s_ch2_ready = pin_q[5];
    wire s_p1_sdi    = pin_q[6];

    // Ready lines double as interrupt sources for the CPU
    assign ch1_ready_irq = s_ch1_ready; // RL6
    assign ch2_ready_irq = s_ch2_ready; // RL6

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [7:0] pin_wr_q;
    reg  [1:0] route_q;
    wire       wr_pin    = sfr_wr && (sfr_addr == `RCP_ADDR_PIN);
    wire       wr_route  = sfr_wr && (sfr_addr == `RCP_ADDR_ROUTE);
    wire       wr_shdata = sfr_wr && (sfr_addr == `RCP_ADDR_SHDATA);
    wire       rd_shdata = sfr_rd && (sfr_addr == `RCP_ADDR_SHDATA);

    // Write map only; reset value holds until software writes
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_wr_q <= `RCP_PIN_RESET; // RL1 RL10
            route_q  <= `RCP_ROUTE_RESET; // RL2
        end else begin
            if (wr_pin) begin
                pin_wr_q <= sfr_wdata; // RL11 RL5
            end
            if (wr_route) begin
                route_q <= sfr_wdata[1:0]; // RL2
            end
        end
    end

    // ****************************************************************
    // Clock divider for the shifter
    // ****************************************************************
    localparam HALF = SCK_DIV / 2;
    reg  [7:0] div_q;
    wire       tick = (div_q == HALF[7:0] - 8'h01);

    // Free-running half-period tick; restarts on each shift start
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 8'h00;
        end else if (tick || (wr_shdata && shift_wr_ready)) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // ****************************************************************
    // Shifter and receive FIFO
    // ****************************************************************
    wire       sh_sck;
    wire       sh_sdo;
    wire [7:0] sh_rx;
    wire       sh_done;
    wire       fifo_in_ready;
    wire [7:0] fifo_head;
    reg        sh_sdi;
    wire       routed = (route_q != `RCP_ROUTE_OFF);

    // A shift may only start when routed and the FIFO can take its result,
    // so a full FIFO refuses software writes instead of dropping bytes.
    assign shift_wr_ready = routed && !shift_busy && fifo_in_ready;

    // Serial input source follows the routing
    always @* begin
        case (route_q)
            `RCP_ROUTE_PORT1: sh_sdi = s_p1_sdi;
            `RCP_ROUTE_CH1:   sh_sdi = s_ch1_data; // RL8
            `RCP_ROUTE_CH2:   sh_sdi = s_ch2_sout; // RL9
            default:          sh_sdi = 1'b0;
        endcase
    end

    rcp_shifter u_shifter (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tick    (tick),
        .start   (wr_shdata && shift_wr_ready), // RL16
        .tx_byte (sfr_wdata),
        .sdi     (sh_sdi),
        .sck_q   (sh_sck),
        .sdo_q   (sh_sdo),
        .rx_byte (sh_rx),
        .done_q  (sh_done),
        .busy_q  (shift_busy)
    );

    rcp_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_data   (sh_rx),
        .in_valid  (sh_done),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_head),
        .out_valid (rx_byte_valid),
        .out_ready (rd_shdata) // RL14
    );

    // ****************************************************************
    // Read path
    // ****************************************************************
    reg [7:0] pin_rd;

    // Separate read map of live radio outputs, unused bits zero
    always @* begin
        pin_rd                    = 8'h00; // RL3 RL4
        pin_rd[`RCP_RD_CH2_READY] = s_ch2_ready;
        pin_rd[`RCP_RD_CH2_CLOCK] = s_ch2_clock;
        pin_rd[`RCP_RD_CH2_SOUT]  = s_ch2_sout;
        pin_rd[`RCP_RD_CH1_READY] = s_ch1_ready; // RL19
        pin_rd[`RCP_RD_CH1_CLOCK] = s_ch1_clock;
        pin_rd[`RCP_RD_CH1_DATA]  = s_ch1_data; // RL20
    end

    // Read data registered one cycle after the strobe; unmapped reads zero
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata  <= 8'h00;
            shift_done <= 1'b0;
        end else begin
            shift_done <= sh_done;
            if (sfr_rd) begin
                case (sfr_addr)
                    `RCP_ADDR_PIN:    sfr_rdata <= pin_rd; // RL20
                    `RCP_ADDR_ROUTE:  sfr_rdata <= {6'h00, route_q};
                    `RCP_ADDR_SHDATA: sfr_rdata <= rx_byte_valid ? fifo_head : 8'h00;
                    default:          sfr_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    reg ch1_clock_d;
    reg ch2_clock_d;
    reg data_in_d;
    reg p1_sck_d;
    reg p1_sdo_d;

    // Direct register drive unless the routing hands a line to the shifter;
    // the select lines always stay with the register bits.
    always @* begin
        ch1_clock_d = pin_wr_q[`RCP_WR_CH1_CLOCK]; // RL7 RL15 RL17
        ch2_clock_d = pin_wr_q[`RCP_WR_CH2_CLOCK]; // RL7
        data_in_d   = pin_wr_q[`RCP_WR_DATA_IN]; // RL7
        p1_sck_d    = 1'b0;
        p1_sdo_d    = 1'b0;
        case (route_q)
            `RCP_ROUTE_PORT1: begin
                p1_sck_d = sh_sck;
                p1_sdo_d = sh_sdo;
            end
            `RCP_ROUTE_CH1: begin
                ch1_clock_d = sh_sck; // RL8
                data_in_d   = sh_sdo; // RL8
            end
            `RCP_ROUTE_CH2: begin
                ch2_clock_d = sh_sck; // RL9
            end
            default: ;
        endcase
    end

    // Outputs from flip-flops, reset to the safe radio levels
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            radio_power_on   <= 1'b1; // RL10
            radio_activate   <= 1'b0; // RL10
            radio_cfg_select <= 1'b0; // RL10
            ch1_clock        <= 1'b0;
            ch2_clock        <= 1'b0;
            radio_data_in    <= 1'b0;
            p1_sck           <= 1'b0;
            p1_sdo           <= 1'b0;
        end else begin
            radio_power_on   <= pin_wr_q[`RCP_WR_POWER_ON]; // RL11
            radio_activate   <= pin_wr_q[`RCP_WR_ACTIVATE]; // RL8 RL9
            radio_cfg_select <= pin_wr_q[`RCP_WR_CFG_SELECT]; // RL8
            ch1_clock        <= ch1_clock_d;
            ch2_clock        <= ch2_clock_d;
            radio_data_in    <= data_in_d;
            p1_sck           <= p1_sck_d;
            p1_sdo           <= p1_sdo_d;
        end
    end
endmodule

// *** rcp_radio_port_monitor.sv ***
// Checker for the radio control port top-level ports
`timescale 1ns/1ps
`include "rcp_defs.vh"
module rcp_radio_port_monitor #(
    parameter SCK_DIV = 8
) (
    input logic       sys_clk,
    input logic       rst_n,
    input logic [7:0] sfr_addr,
    input logic       sfr_wr,
    input logic       sfr_rd,
    input logic [7:0] sfr_wdata,
    input logic [7:0] sfr_rdata,
    input logic       shift_wr_ready,
    input logic       shift_done,
    input logic       shift_busy,
    input logic       radio_power_on,
    input logic       radio_activate,
    input logic       radio_cfg_select,
    input logic       ch1_clock,
    input logic       ch2_clock,
    input logic       radio_data_in
);
    // ********
    // Helper state
    // ********
    localparam int DMIN = 7 * SCK_DIV;
    localparam int DMAX = 9 * SCK_DIV;
    logic [1:0] route_q;
    logic [7:0] tx_q;
    logic [3:0] rise_q;
    logic       ck_q;
    wire        sck   = route_q[0] ? ch2_clock : ch1_clock;
    wire        start = sfr_wr && sfr_addr == `RCP_ADDR_SHDATA && shift_wr_ready;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Shadow routing, byte sent and routed clock rises since start
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            route_q <= 2'h0;
            tx_q    <= 8'h00;
            rise_q  <= 4'h0;
            ck_q    <= 1'b0;
        end else begin
            ck_q <= sck;
            if (sfr_wr && sfr_addr == `RCP_ADDR_ROUTE)
                route_q <= sfr_wdata[1:0];
            if (start) begin
                tx_q   <= sfr_wdata;
                rise_q <= 4'h0;
            end else if (sck && !ck_q)
                rise_q <= rise_q + 4'h1;
        end
    end
    // ********
    // Assertions
    // ********
    AST_RESET_OUT: assert property (
        $rose(rst_n) |-> radio_power_on && !radio_activate && !radio_cfg_select)
        else $error("control outputs off default after reset");
    AST_PIN_WRITE: assert property (
        sfr_wr && sfr_addr == `RCP_ADDR_PIN |-> ##2
        {radio_power_on, radio_activate, radio_cfg_select} ==
        {$past(sfr_wdata[7], 2), $past(sfr_wdata[6], 2), $past(sfr_wdata[3], 2)})
        else $error("select lines do not follow pin write");
    AST_DIRECT: assert property (
        (sfr_wr && sfr_addr == `RCP_ADDR_PIN && !route_q[1]) ##1 !route_q[1] ##1
        !route_q[1] |-> {ch2_clock, ch1_clock, radio_data_in} ==
        {$past(sfr_wdata[5], 2), $past(sfr_wdata[1], 2), $past(sfr_wdata[0], 2)})
        else $error("radio pins not direct in routes 0x");
    AST_READ_ZERO: assert property (
        sfr_rd && sfr_addr == `RCP_ADDR_PIN |=> !sfr_rdata[7] && !sfr_rdata[3])
        else $error("unused pin read bits not zero");
    AST_ROUTE_READ: assert property (
        sfr_rd && sfr_addr == `RCP_ADDR_ROUTE |=> sfr_rdata == {6'h00, $past(route_q)})
        else $error("routing read back wrong");
    AST_SHIFT_TIME: assert property (
        start |-> ##[DMIN:DMAX] shift_done)
        else $error("shift did not finish in time");
    AST_RISE_COUNT: assert property (
        shift_done && route_q[1] |-> rise_q == 4'h8)
        else $error("routed clock rise count not eight");
    AST_MSB_FIRST: assert property (
        route_q == `RCP_ROUTE_CH1 && shift_busy && ch1_clock && !ck_q |->
        radio_data_in == tx_q[3'h7 - rise_q[2:0]])
        else $error("shift data bit order wrong");
endmodule
bind rcp_radio_port rcp_radio_port_monitor #(.SCK_DIV(SCK_DIV)) rcp_radio_port_monitor_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .shift_wr_ready(shift_wr_ready), .shift_done(shift_done), .shift_busy(shift_busy),
    .radio_power_on(radio_power_on), .radio_activate(radio_activate),
    .radio_cfg_select(radio_cfg_select), .ch1_clock(ch1_clock), .ch2_clock(ch2_clock),
    .radio_data_in(radio_data_in));

// *** rcp_radio_model.sv ***
// Behavioural radio subsystem on the far side of the pin port
`timescale 1ns/1ps
module rcp_radio_model (
    input  wire       ch1_clock,
    input  wire       ch2_clock,
    input  wire       radio_data_in,
    input  wire       load,
    input  wire [7:0] tx1,
    input  wire [7:0] tx2,
    output wire       ch1_data,
    output wire       ch1_clock_echo,
    output reg        ch1_data_ready,
    output wire       ch2_serial_out,
    output wire       ch2_clock_echo,
    output reg        ch2_data_ready,
    output reg  [7:0] rx1_q
);
    reg [7:0] sh1_q;
    reg [7:0] sh2_q;
    reg [3:0] n1_q;
    reg [3:0] n2_q;
    // Clock pins read back as driven; bit rate is whatever the CPU toggles
    assign ch1_clock_echo = ch1_clock;
    assign ch2_clock_echo = ch2_clock;
    assign ch1_data       = sh1_q[7];
    assign ch2_serial_out = sh2_q[7];
    // Packet arrives: payload buffered, both ready lines raised
    always @(posedge load) begin
        sh1_q          = tx1;
        sh2_q          = tx2;
        n1_q           = 4'h0;
        n2_q           = 4'h0;
        ch1_data_ready = 1'b1;
        ch2_data_ready = 1'b1;
    end
    // Input bits taken on the rising clock, msb first
    always @(posedge ch1_clock) begin
        rx1_q = {rx1_q[6:0], radio_data_in};
    end
    // Payload out on falling clock; spent bits refill with changing junk
    always @(negedge ch1_clock) begin
        sh1_q = {sh1_q[6:0], ~sh1_q[0]};
        n1_q  = n1_q + 4'h1;
        if (n1_q == 4'h8)
            ch1_data_ready = 1'b0;
    end
    // Second channel sends its payload the same way on its own clock, but takes no input bits
    always @(negedge ch2_clock) begin
        sh2_q = {sh2_q[6:0], ~sh2_q[0]};
        n2_q  = n2_q + 4'h1;
        if (n2_q == 4'h8)
            ch2_data_ready = 1'b0;
    end
endmodule

// *** test_rcp_radio_port.sv ***
// Self-checking bench for the radio control port
`timescale 1ns/1ps
`include "rcp_defs.vh"
module test_rcp_radio_port;
    reg        sys_clk, rst_n, sfr_wr, sfr_rd, load;
    reg  [7:0] sfr_addr, sfr_wdata, tx1, tx2, rd, v;
    wire [7:0] sfr_rdata, rx1;
    wire       shift_wr_ready, shift_done, shift_busy, rx_byte_valid;
    wire       radio_power_on, radio_activate, radio_cfg_select, p1_sck, p1_sdo;
    wire       ch1_clock, ch2_clock, radio_data_in, ch1_data, ch1_clock_echo;
    wire       ch1_data_ready, ch2_serial_out, ch2_clock_echo, ch2_data_ready;
    wire       ch1_ready_irq, ch2_ready_irq;
    integer    errors, compares, i, n;
    rcp_radio_port rcp_radio_port_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .shift_wr_ready(shift_wr_ready), .shift_done(shift_done),
        .shift_busy(shift_busy), .rx_byte_valid(rx_byte_valid),
        .radio_power_on(radio_power_on), .radio_activate(radio_activate),
        .radio_cfg_select(radio_cfg_select), .ch1_clock(ch1_clock),
        .ch2_clock(ch2_clock), .radio_data_in(radio_data_in), .ch1_data(ch1_data),
        .ch1_clock_echo(ch1_clock_echo), .ch1_data_ready(ch1_data_ready),
        .ch2_serial_out(ch2_serial_out), .ch2_clock_echo(ch2_clock_echo),
        .ch2_data_ready(ch2_data_ready), .ch1_ready_irq(ch1_ready_irq),
        .ch2_ready_irq(ch2_ready_irq), .p1_sck(p1_sck), .p1_sdo(p1_sdo), .p1_sdi(1'b0));
    rcp_radio_model rcp_radio_model_i (
        .ch1_clock(ch1_clock), .ch2_clock(ch2_clock), .radio_data_in(radio_data_in),
        .load(load), .tx1(tx1), .tx2(tx2), .ch1_data(ch1_data),
        .ch1_clock_echo(ch1_clock_echo), .ch1_data_ready(ch1_data_ready),
        .ch2_serial_out(ch2_serial_out), .ch2_clock_echo(ch2_clock_echo),
        .ch2_data_ready(ch2_data_ready), .rx1_q(rx1));
    // ********
    // Helpers
    // ********
    task check(input [7:0] got, input [7:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    // Strobe for one edge, then one idle cycle so strobes never collide
    task wr(input [7:0] a, input [7:0] d);
        begin
            sfr_addr  = a;
            sfr_wdata = d;
            sfr_wr    = 1'b1;
            @(negedge sys_clk);
            sfr_wr = 1'b0;
            @(negedge sys_clk);
        end
    endtask
    task rdx(input [7:0] a);
        begin
            sfr_addr = a;
            sfr_rd   = 1'b1;
            @(negedge sys_clk);
            sfr_rd = 1'b0;
            rd     = sfr_rdata;
            @(negedge sys_clk);
        end
    endtask
    task pkt(input [7:0] a, input [7:0] b);
        begin
            tx1  = a;
            tx2  = b;
            load = 1'b1;
            @(negedge sys_clk);
            load = 1'b0;
        end
    endtask
    task shift(input [7:0] d);
        begin
            wr(`RCP_ADDR_SHDATA, d);
            n = 0;
            while (shift_done !== 1'b1 && n < 200) begin
                @(negedge sys_clk);
                n = n + 1;
            end
            check({7'h0, shift_done}, 8'h01);
        end
    endtask
    task final_report;
        begin
            $display("errors %0d compares %0d", errors, compares);
            if (errors == 0 && compares > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // ********
    // Stimulus
    // ********
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Hang guard, far beyond the expected run of some 800 cycles
    initial begin
        #200000;
        errors = errors + 1;
        final_report;
    end
    initial begin
        {rst_n, sfr_wr, sfr_rd, load, sfr_addr, sfr_wdata, tx1, tx2} = 0;
        errors   = 0;
        compares = 0;
        repeat (2) @(negedge sys_clk);
        check({radio_power_on, radio_activate, radio_cfg_select}, 8'h04);
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (20) @(negedge sys_clk);
        check({radio_power_on, radio_activate, radio_cfg_select}, 8'h04);
        $display("reset test done");
        // Pin writes in route 00 drive every used output bit
        for (i = 0; i < 4; i = i + 1) begin
            v = 8'h43 + 8'h3d * i;
            wr(`RCP_ADDR_PIN, v);
            @(negedge sys_clk);
            check({radio_power_on, radio_activate, ch2_clock, 1'b0, radio_cfg_select, 1'b0,
                   ch1_clock, radio_data_in}, v & 8'heb);
        end
        $display("pin write test done");
        pkt(8'h80, 8'h80);
        wr(`RCP_ADDR_PIN, 8'h22);
        repeat (6) @(negedge sys_clk);
        rdx(`RCP_ADDR_PIN);
        check(rd, 8'h77);
        check({ch2_ready_irq, ch1_ready_irq}, 8'h03);
        wr(`RCP_ADDR_PIN, 8'h80);
        repeat (6) @(negedge sys_clk);
        rdx(`RCP_ADDR_PIN);
        check(rd, 8'h44);
        $display("pin read test done");
        for (i = 0; i < 4; i = i + 1) begin
            wr(`RCP_ADDR_ROUTE, 8'hfc | i);
            rdx(`RCP_ADDR_ROUTE);
            check(rd, i);
        end
        $display("route test done");
        // Channel 1 shifts fill the receive buffer until it refuses
        wr(`RCP_ADDR_ROUTE, 8'h02);
        for (i = 0; i < 8; i = i + 1) begin
            pkt(8'hc0 + i, 8'h00);
            shift(8'ha5 ^ i);
            check(rx1, 8'ha5 ^ i);
        end
        check({7'h0, shift_wr_ready}, 8'h00);
        wr(`RCP_ADDR_SHDATA, 8'h11);
        check({7'h0, shift_busy}, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            rdx(`RCP_ADDR_SHDATA);
            check(rd, 8'hc0 + i);
        end
        check({7'h0, rx_byte_valid}, 8'h00);
        rdx(`RCP_ADDR_SHDATA);
        check(rd, 8'h00);
        $display("channel 1 shift test done");
        wr(`RCP_ADDR_ROUTE, 8'h03);
        pkt(8'h00, 8'h96);
        shift(8'h0f);
        rdx(`RCP_ADDR_SHDATA);
        check(rd, 8'h96);
        check({7'h0, ch1_clock}, 8'h00);
        $display("channel 2 shift test done");
        wr(`RCP_ADDR_ROUTE, 8'h01);
        shift(8'h3c);
        check({6'h0, ch2_clock, ch1_clock}, 8'h00);
        rdx(`RCP_ADDR_SHDATA);
        check(rd, 8'h00);
        $display("port 1 route test done");
        final_report;
    end
endmodule
